/* hdl/sprx_defines.vh */
// Register offsets, field positions, reset values and codes for the receive front end.
`ifndef SPRX_DEFINES_VH
`define SPRX_DEFINES_VH
`define SPRX_ADDR_MODE        7'h24
`define SPRX_ADDR_GPA         7'h27
`define SPRX_ADDR_GPB         7'h28
`define SPRX_ADDR_PWR         7'h33
`define SPRX_ADDR_CS1         7'h2C
`define SPRX_ADDR_CS2         7'h2D
`define SPRX_ADDR_CS3         7'h2E
`define SPRX_ADDR_CS4         7'h2F
`define SPRX_ADDR_CS5         7'h30
`define SPRX_ADDR_FLAG        7'h31
`define SPRX_RST_MODE         8'h01
`define SPRX_RST_GPA          8'h32
`define SPRX_RST_GPB          8'h04
`define SPRX_RST_PWR          8'h20
`define SPRX_BIT_INTYPE       0
`define SPRX_BIT_MUX_LO       1
`define SPRX_BIT_MUX_HI       2
`define SPRX_BIT_MASK         6
`define SPRX_BIT_PD           5
`define SPRX_FN_CMOS          4'hE
`define SPRX_FN_COMP          4'hF
`define SPRX_FN_USER          4'h8
`define SPRX_FN_UPD           4'h9
`define SPRX_CS_BITS          8'h28
`define SPRX_BLOCK_FRAMES     8'hBF
`endif

/* hdl/sprx_subframe.v */
// Subframe slot parser: splits a 32-slot subframe into sample and flag bits.
`timescale 1ns/1ps
`default_nettype none
module sprx_subframe (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        enable,
    input  wire        bit_valid,
    input  wire        bit_data,
    input  wire        block_start,
    output reg  [23:0] sample_reg,
    output reg  [3:0]  vucp_reg,
    output reg         done_reg,
    output reg         first_reg
);
    reg [4:0]  slot_reg;
    reg [27:0] shift_reg;
    reg        blk_reg;
    // Slots 0..3 are preamble, 4..27 sample LSB first, 28..31 V U C P.
    always @(posedge ref_clk) begin
        if (sys_rst || !enable) begin
            slot_reg   <= 5'h00;
            shift_reg  <= 28'h0000000;
            sample_reg <= 24'h000000;
            vucp_reg   <= 4'h0;
            done_reg   <= 1'b0;
            first_reg  <= 1'b0;
            blk_reg    <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (bit_valid) begin
                slot_reg  <= slot_reg + 5'h01;
                shift_reg <= {bit_data, shift_reg[27:1]};
                if (slot_reg == 5'h00)
                    blk_reg <= block_start;
                if (slot_reg == 5'h1F) begin
                    // Slot 31 is still on the wire, so slot n sits at index n-3.
                    sample_reg <= shift_reg[24:1];
                    vucp_reg   <= {shift_reg[25], shift_reg[26], shift_reg[27], bit_data};
                    first_reg  <= blk_reg;
                    done_reg   <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hdl/sprx_top.v */
// Receive front end: input select, sample recovery, truncation, routing and status capture.
// Operation
// - Primary input type bit: comparator or CMOS
// - Two-bit mux picks one of four inputs
// - Pin codes 1110/1111 make receive inputs
// - Power-down bit disables the receiver
// - Recover sample and V U C P bits
// - Route audio to DAC1, mute on non-audio
// - Deliver samples to audio interfaces and transmitter
// - User bits available on general-purpose pins
// - Capture 24 bits from slots 4-27
// - Mask bit zero truncates to signalled length
// - Shorter interface word drops excess LSBs
// - Longer interface word pads zero LSBs
// - Transmitter gets 24 bits unless truncated
// - Pre-emphasis plus DAC1 route enables de-emphasis
// - Channel 1 status into five read-only registers
// - Update flag set on new status, cleared on read
// - Update flag selectable on any output pin
// - Pre-emphasis taken from status bit 3
`timescale 1ns/1ps
`default_nettype none
`include "sprx_defines.vh"
// Slots arrive biphase-decoded, one per bit_valid pulse, on the
// input that the mux picks. A parser splits each subframe into a
// sample and its flags; this module fits the sample to each
// consumer and gathers channel 1 status.
// The far side is taken as synchronous to ref_clk, so no input
// is resampled here.

module sprx_top (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [6:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_reg,
    input  wire        rx_input_primary,
    input  wire        rx_input_second,
    input  wire        rx_input_third,
    input  wire        rx_input_fourth,
    input  wire        bit_valid,
    input  wire        bit_block_start,
    input  wire        bit_channel2,
    input  wire [1:0]  aif_word_len,
    input  wire        route_to_dac1,
    output wire        primary_comparator_en,
    output wire [2:0]  gp_pin_is_input,
    output wire [2:0]  gp_pin_comparator,
    output wire [2:0]  gp_pin_out,
    output wire [1:0]  rx_input_mux_sel,
    output wire        rx_selected_data,
    output wire        rx_enable,
    output reg  [23:0] dac1_sample_reg,
    output reg         dac1_mute_reg,
    output reg         dac1_preemphasis_flag_en_reg,
    output reg  [23:0] aif_sample_reg,
    output reg  [23:0] tx_sample_reg,
    output reg  [3:0]  vucp_out_reg,
    output reg         sample_strobe_reg,
    output reg         sample_channel2_reg,
    output wire        status_update_flag
);
    // Software-visible control registers.
    reg  [7:0]  mode_reg;
    reg  [7:0]  gpa_reg;
    reg  [7:0]  gpb_reg;
    reg  [7:0]  pwr_reg;

    // Status gathering and flag state.
    reg  [39:0] cs_shift_reg;
    reg  [39:0] cs_hold_reg;
    reg  [7:0]  cs_count_reg;
    reg         cs_live_reg;
    reg         upd_reg;
    reg         user_bit_reg;

    // Combinational helpers.
    reg         sel_data;
    reg  [4:0]  sig_len;
    reg  [23:0] aif_next;

    // Parser and length-cut results.
    wire [23:0] sf_sample;
    wire [3:0]  sf_vucp;
    wire        sf_done;
    wire        sf_first;
    wire [23:0] trunc_sample;
    wire [23:0] fwd_sample;

    // Decoded control and status fields.
    wire [11:0] pin_fn;
    wire        length_trunc_mask;
    wire        max_length_flag;
    wire [2:0]  rx_length_code;
    wire        preemphasis_flag;
    wire        nonaudio_flag;
    wire        rd_hit;

    // Register decode and software writes; status registers are not writable.
    // Other addresses leave every control register as it was.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_reg <= `SPRX_RST_MODE;
            gpa_reg  <= `SPRX_RST_GPA;
            gpb_reg  <= `SPRX_RST_GPB;
            pwr_reg  <= `SPRX_RST_PWR;
        end else if (reg_wr) begin
            case (reg_addr)
                `SPRX_ADDR_MODE: mode_reg <= reg_wdata;
                `SPRX_ADDR_GPA:  gpa_reg  <= reg_wdata;
                `SPRX_ADDR_GPB:  gpb_reg  <= reg_wdata;
                `SPRX_ADDR_PWR:  pwr_reg  <= reg_wdata;
                default:         mode_reg <= mode_reg;
            endcase
        end
    end

    // Input type of the primary pin.
    // The pad circuit sits outside; only its select leaves here.
    // primary input type
    assign primary_comparator_en = mode_reg[`SPRX_BIT_INTYPE];
    assign rx_input_mux_sel      = mode_reg[`SPRX_BIT_MUX_HI:`SPRX_BIT_MUX_LO];
    assign length_trunc_mask     = mode_reg[`SPRX_BIT_MASK];
    assign pin_fn                = {gpb_reg[3:0], gpa_reg[7:4], gpa_reg[3:0]};

    // Per-pin function decode: input codes turn the pin into a receiver input.
    // Pin a is the low nibble of the first config register, pin b
    // its high nibble, pin c the low nibble of the second one.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
            // Each pin decodes its own nibble.
            wire [3:0] fn;
            assign fn = pin_fn[gi*4+3:gi*4];
            assign gp_pin_is_input[gi]   = (fn == `SPRX_FN_CMOS) || (fn == `SPRX_FN_COMP);
            assign gp_pin_comparator[gi] = (fn == `SPRX_FN_COMP);
            // Output codes choose what a non-input pin shows.
            // user data out
            assign gp_pin_out[gi] = (fn == `SPRX_FN_USER) ? user_bit_reg :
                                    (fn == `SPRX_FN_UPD)  ? upd_reg : 1'b0;
        end
    endgenerate

    // Input multiplexer; a pin not configured as input reads low so it cannot
    // feed its own output drive back into the decoder.
    // Software must set the pin code before pointing the mux at it.
    // input mux
    always @* begin
        case (rx_input_mux_sel)
            2'h0:    sel_data = rx_input_primary;
            2'h1:    sel_data = rx_input_second & gp_pin_is_input[0];
            2'h2:    sel_data = rx_input_third & gp_pin_is_input[1];
            2'h3:    sel_data = rx_input_fourth & gp_pin_is_input[2];
            default: sel_data = 1'b0;
        endcase
    end
    assign rx_selected_data = sel_data;

    // Power-down holds the whole decode path in reset.
    // Registers stay writable, so setup can precede power-up.
    // Status is cleared too; the flag waits for a read.
    // power-down gate
    assign rx_enable = ~pwr_reg[`SPRX_BIT_PD];

    // Subframe parsing of the recovered bit stream.
    // Sample and flags stand from one done pulse to the next.
    // Power-down restarts the slot count.
    // VUCP recovery
    sprx_subframe u_subframe (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .enable      (rx_enable),
        .bit_valid   (bit_valid),
        .bit_data    (sel_data),
        .block_start (bit_block_start),
        .sample_reg  (sf_sample),
        .vucp_reg    (sf_vucp),
        .done_reg    (sf_done),
        .first_reg   (sf_first)
    );

    // Held status fields steer truncation and DAC behaviour.
    // Taken from the hold copy, so a half-gathered block never
    // changes behaviour in mid-stream.
    // pre-emphasis bit
    assign preemphasis_flag = cs_hold_reg[3];
    assign nonaudio_flag    = cs_hold_reg[1];
    assign max_length_flag  = cs_hold_reg[32];
    assign rx_length_code   = cs_hold_reg[35:33];

    // Signalled length; an unindicated or reserved code keeps all 24 bits.
    // Codes 0, 3 and 7 fall to the default branch.
    // Max flag set gives 20 to 24 bits, clear gives 16 to 20.
    // source declares length
    always @* begin
        case (rx_length_code)
            3'h1:    sig_len = max_length_flag ? 5'h14 : 5'h10;
            3'h2:    sig_len = max_length_flag ? 5'h16 : 5'h12;
            3'h4:    sig_len = max_length_flag ? 5'h17 : 5'h13;
            3'h5:    sig_len = max_length_flag ? 5'h18 : 5'h14;
            3'h6:    sig_len = max_length_flag ? 5'h15 : 5'h11;
            default: sig_len = 5'h18;
        endcase
    end

    // Length cut: the top sig_len bits stay, the rest read zero.
    // The helper is combinational and adds no latency.
    sprx_trunc u_trunc (
        .sample_in  (sf_sample),
        .keep_bits  (sig_len),
        .sample_out (trunc_sample)
    );

    // Mask set: all 24 received bits reach DAC1 and the transmitter; the interface word cut still applies.
    // truncation mask
    assign fwd_sample = length_trunc_mask ? sf_sample : trunc_sample;

    // Fit to interface word length: 0=16, 1=20, 2=24, 3=32 bits, MSB aligned.
    // This cut cannot be masked, unlike the length cut.
    // Code 3 passes all 24 bits; the serialiser pads the rest.
    // drop excess LSBs
    always @* begin
        case (aif_word_len)
            2'h0:    aif_next = {fwd_sample[23:8], 8'h00};
            2'h1:    aif_next = {fwd_sample[23:4], 4'h0};
            default: aif_next = fwd_sample;
        endcase
    end

    // Sample outputs update once per completed subframe.
    // Mute and de-emphasis follow the route every cycle, so a
    // route change needs no new subframe.
    always @(posedge ref_clk) begin
        if (sys_rst || !rx_enable) begin
            dac1_sample_reg     <= 24'h000000;
            dac1_mute_reg       <= 1'b1;
            dac1_preemphasis_flag_en_reg  <= 1'b0;
            aif_sample_reg      <= 24'h000000;
            tx_sample_reg       <= 24'h000000;
            vucp_out_reg        <= 4'h0;
            sample_strobe_reg   <= 1'b0;
            sample_channel2_reg <= 1'b0;
            user_bit_reg        <= 1'b0;
        end else begin
            sample_strobe_reg <= sf_done;
            dac1_mute_reg      <= ~route_to_dac1 | nonaudio_flag;
            dac1_preemphasis_flag_en_reg <= route_to_dac1 & preemphasis_flag;
            // Every consumer takes the same subframe on one edge.
            if (sf_done) begin
                dac1_sample_reg     <= fwd_sample;
                aif_sample_reg      <= aif_next;
                tx_sample_reg       <= fwd_sample;
                vucp_out_reg        <= sf_vucp;
                sample_channel2_reg <= bit_channel2;
                user_bit_reg        <= sf_vucp[2];
            end
        end
    end

    // Channel 1 status gathering; outside reset and power-down the hold copy changes only on a full block.
    // Bits past the 40 kept are counted, not stored. Only a block-start
    // subframe restarts the count, so lost sync stalls the hold copy.
    // channel 1 only
    always @(posedge ref_clk) begin
        if (sys_rst || !rx_enable) begin
            cs_shift_reg <= 40'h0000000000;
            cs_hold_reg  <= 40'h0000000000;
            cs_count_reg <= 8'h00;
            cs_live_reg  <= 1'b0;
        end else if (sf_done && !bit_channel2) begin
            // A block-start subframe restarts at bit 0.
            if (sf_first) begin
                cs_shift_reg <= {39'h0, sf_vucp[1]};
                cs_count_reg <= 8'h01;
                cs_live_reg  <= 1'b1;
            end else if (cs_live_reg) begin
                if (cs_count_reg < `SPRX_CS_BITS)
                    cs_shift_reg[cs_count_reg[5:0]] <= sf_vucp[1];
                // The 192nd channel 1 subframe closes the block.
                if (cs_count_reg == `SPRX_BLOCK_FRAMES) begin
                    cs_hold_reg <= cs_shift_reg;
                    cs_live_reg <= 1'b0;
                end
                cs_count_reg <= cs_count_reg + 8'h01;
            end
        end
    end

    // Update flag: set on a new block, cleared by reading it; set wins.
    // The set term mirrors the hold-copy update, so the flag rises
    // on the edge at which the new status becomes readable.
    // update flag
    assign rd_hit = reg_rd && (reg_addr == `SPRX_ADDR_FLAG);
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            upd_reg <= 1'b0;
        end else if (rx_enable && sf_done && !bit_channel2 && cs_live_reg &&
                     !sf_first && (cs_count_reg == `SPRX_BLOCK_FRAMES)) begin
            upd_reg <= 1'b1;
        end else if (rd_hit) begin
            upd_reg <= 1'b0;
        end
    end
    // The flag also leaves on its own port.
    assign status_update_flag = upd_reg;

    // Read data, one cycle after the read strobe; unmapped reads return zero.
    // The flag reads as it stood before its clear.
    // Data stands until the next read strobe.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SPRX_ADDR_MODE: reg_rdata_reg <= mode_reg;
                `SPRX_ADDR_GPA:  reg_rdata_reg <= gpa_reg;
                `SPRX_ADDR_GPB:  reg_rdata_reg <= gpb_reg;
                `SPRX_ADDR_PWR:  reg_rdata_reg <= pwr_reg;
                `SPRX_ADDR_CS1:  reg_rdata_reg <= cs_hold_reg[7:0];
                `SPRX_ADDR_CS2:  reg_rdata_reg <= cs_hold_reg[15:8];
                `SPRX_ADDR_CS3:  reg_rdata_reg <= cs_hold_reg[23:16];
                `SPRX_ADDR_CS4:  reg_rdata_reg <= cs_hold_reg[31:24];
                `SPRX_ADDR_CS5:  reg_rdata_reg <= cs_hold_reg[39:32];
                `SPRX_ADDR_FLAG: reg_rdata_reg <= {7'h00, upd_reg};
                default:         reg_rdata_reg <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* hdl/sprx_trunc.v */
// Sample length truncation helper.
`timescale 1ns/1ps
`default_nettype none
module sprx_trunc (
    input  wire [23:0] sample_in,
    input  wire [4:0]  keep_bits,
    output wire [23:0] sample_out
);
    wire [23:0] ones;
    // Keep the top keep_bits bits and zero the rest.
    assign ones = ~(24'hFFFFFF >> keep_bits);
    assign sample_out = sample_in & ones;
endmodule
`default_nettype wire

/* test/sprx_assertions.sv */
// Port-level assertions for the receive front end, with the bind that attaches them.
`timescale 1ns/1ps
`default_nettype none
`include "sprx_defines.vh"
module sprx_chk (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata_reg,
    input wire logic        rx_input_primary,
    input wire logic [2:0]  gp_pin_is_input,
    input wire logic [2:0]  gp_pin_comparator,
    input wire logic [2:0]  gp_pin_out,
    input wire logic [1:0]  rx_input_mux_sel,
    input wire logic        rx_selected_data,
    input wire logic        rx_enable,
    input wire logic        primary_comparator_en,
    input wire logic [23:0] aif_sample_reg,
    input wire logic [23:0] tx_sample_reg,
    input wire logic        sample_strobe_reg,
    input wire logic        status_update_flag
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Control fields take effect in the cycle after their register is written.
    chk_input_type_bit: assert property (
        reg_wr && reg_addr == `SPRX_ADDR_MODE |=> primary_comparator_en == $past(reg_wdata[0]))
        else $error("input type bit not applied");
    chk_mux_field: assert property (
        reg_wr && reg_addr == `SPRX_ADDR_MODE |=> rx_input_mux_sel == $past(reg_wdata[2:1]))
        else $error("mux field not applied");
    chk_mux_primary: assert property (
        rx_input_mux_sel == 2'h0 |-> rx_selected_data == rx_input_primary)
        else $error("primary input not routed");
    chk_power_bit: assert property (
        reg_wr && reg_addr == `SPRX_ADDR_PWR |=> rx_enable == !$past(reg_wdata[5]))
        else $error("power-down bit not applied");
    // A receiver that stayed off for two cycles must not report a subframe.
    chk_off_silent: assert property (
        !rx_enable && $past(!rx_enable) |-> !sample_strobe_reg)
        else $error("strobe while powered down");
    chk_strobe_single: assert property (
        sample_strobe_reg |=> !sample_strobe_reg [*8])
        else $error("subframe strobe too long or too close");
    chk_samples_stand: assert property (
        !sample_strobe_reg && rx_enable && $past(rx_enable)
        |-> $stable(aif_sample_reg) && $stable(tx_sample_reg))
        else $error("sample outputs changed without strobe");
    chk_flag_read: assert property (
        reg_rd && reg_addr == `SPRX_ADDR_FLAG |=> reg_rdata_reg == {7'h00, $past(status_update_flag)})
        else $error("flag readback wrong");
    chk_flag_holds: assert property (
        status_update_flag && rx_enable && !(reg_rd && reg_addr == `SPRX_ADDR_FLAG)
        |=> status_update_flag)
        else $error("update flag dropped without readback");
    // Receive codes leave a pin as an input, so it never drives a flag out.
    chk_input_pins_quiet: assert property (
        (gp_pin_is_input & gp_pin_out) == 3'h0 && (gp_pin_comparator & ~gp_pin_is_input) == 3'h0)
        else $error("input pin drives output or comparator without input");
    cover property ($rose(status_update_flag));
    cover property (status_update_flag && reg_rd && reg_addr == `SPRX_ADDR_FLAG);
    cover property (sample_strobe_reg && rx_input_mux_sel == 2'h3);
endmodule
bind sprx_top sprx_chk u_chk (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_reg, .rx_input_primary, .gp_pin_is_input, .gp_pin_comparator, .gp_pin_out,
    .rx_input_mux_sel, .rx_selected_data, .rx_enable, .primary_comparator_en,
    .aif_sample_reg, .tx_sample_reg, .sample_strobe_reg, .status_update_flag);
`default_nettype wire

/* test/sprx_source.sv */
// Behavioural stream source that sends subframes as recovered slot bits.
`timescale 1ns/1ps
`default_nettype none
module sprx_source (
    input  wire logic       ref_clk,
    input  wire logic [1:0] sel,
    output var  logic [3:0] pins,
    output var  logic       bit_valid,
    output var  logic       bit_block_start,
    output var  logic       bit_channel2
);
    // Lines rest at known levels from time zero.
    initial begin
        pins = 4'h0;
        bit_valid = 1'b0;
        bit_block_start = 1'b0;
        bit_channel2 = 1'b0;
    end
    // Only the chosen input carries the bit; the others carry its inverse,
    // so a wrong selection shows up as an inverted sample.
    task automatic send(input logic [23:0] s, input logic v, u, c, b, ch);
        logic [31:0] slots;
        slots = {^{s, v, u, c}, c, u, v, s, 4'h0};
        for (int i = 0; i < 32; i++) begin
            @(posedge ref_clk);
            bit_valid <= 1'b1;
            bit_block_start <= b;
            bit_channel2 <= ch;
            pins <= slots[i] ? (4'h1 << sel) : ~(4'h1 << sel);
        end
        @(posedge ref_clk);
        bit_valid <= 1'b0;
        pins <= ~pins;  // A released line shows the inverse of its last bit.
        repeat (1) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* test/sprx_top_tb.sv */
// Self-checking bench for the receive front end.
`timescale 1ns/1ps
`default_nettype none
`include "sprx_defines.vh"
module sprx_top_tb;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, route_to_dac1 = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] aif_word_len = 2'h2, sel = 2'h0;
    logic [191:0] cs = {152'h0, 40'h03_00_21_5A_08};
    wire logic [3:0] pins;
    wire logic bit_valid, bit_block_start, bit_channel2, primary_comparator_en, rx_enable;
    wire logic rx_selected_data, dac1_mute_reg, dac1_preemphasis_flag_en_reg, sample_strobe_reg;
    wire logic sample_channel2_reg, status_update_flag;
    wire logic [7:0] reg_rdata_reg;
    wire logic [2:0] gp_pin_is_input, gp_pin_comparator, gp_pin_out;
    wire logic [1:0] rx_input_mux_sel;
    wire logic [23:0] dac1_sample_reg, aif_sample_reg, tx_sample_reg;
    wire logic [3:0] vucp_out_reg;
    int n_errors = 0, checks = 0, cycles = 0, n;
    sprx_source src (.ref_clk, .sel, .pins, .bit_valid, .bit_block_start, .bit_channel2);
    sprx_top dut (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_reg,
        .rx_input_primary(pins[0]), .rx_input_second(pins[1]), .rx_input_third(pins[2]),
        .rx_input_fourth(pins[3]), .bit_valid, .bit_block_start, .bit_channel2, .aif_word_len,
        .route_to_dac1, .primary_comparator_en, .gp_pin_is_input, .gp_pin_comparator,
        .gp_pin_out, .rx_input_mux_sel, .rx_selected_data, .rx_enable, .dac1_sample_reg,
        .dac1_mute_reg, .dac1_preemphasis_flag_en_reg, .aif_sample_reg, .tx_sample_reg, .vucp_out_reg,
        .sample_strobe_reg, .sample_channel2_reg, .status_update_flag);
    // Free-running 25 MHz clock.
    initial forever #20 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [23:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register strobes are held for exactly the one edge that takes them.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata_reg, exp);
    endtask
    task automatic sf(input logic [23:0] s, input logic v, u, c, b, ch);
        src.send(s, v, u, c, b, ch);
        #1;
        if (rx_enable === 1'b1) begin
            check("strobe", sample_strobe_reg, 1'b1);
            check("vucp", vucp_out_reg, {v, u, c, ^{s, v, u, c}});
            check("chan2", sample_channel2_reg, ch);
        end
    endtask
    // Keeps the top k bits of a 24-bit sample and zeroes the rest.
    function automatic logic [23:0] keep(input logic [23:0] s, input int k);
        return s & ~((24'h1 << (24 - k)) - 24'h1);
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The full sequence needs about 13500 cycles; a hang is cut off well after that.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`SPRX_ADDR_MODE, 8'h01);
        rd(`SPRX_ADDR_GPA, 8'h32);
        rd(`SPRX_ADDR_GPB, 8'h04);
        rd(`SPRX_ADDR_PWR, 8'h20);
        rd(7'h10, 8'h00);
        check("in type", primary_comparator_en, 1'b1);
        sf(24'hABCDEF, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        check("off sample", aif_sample_reg, 24'h0);
        wr(`SPRX_ADDR_PWR, 8'h00);
        wr(`SPRX_ADDR_GPA, 8'hFE);
        wr(`SPRX_ADDR_GPB, 8'h0F);
        #1 check("pin in", gp_pin_is_input, 3'h7);
        check("pin cmp", gp_pin_comparator, 3'h6);
        check("rx on", rx_enable, 1'b1);
        $display("test reset and power done");
        for (int s = 0; s < 4; s++) begin
            wr(`SPRX_ADDR_MODE, {5'h00, s[1:0], 1'b0});
            sel <= s[1:0];
            #1 check("mux", rx_input_mux_sel, s[1:0]);
            sf({s[1:0], 22'h1A5C3D}, s[0], s[1], 1'b1, 1'b0, 1'b0);
            check("aif", aif_sample_reg, {s[1:0], 22'h1A5C3D});
            check("tx", tx_sample_reg, {s[1:0], 22'h1A5C3D});
        end
        check("in type", primary_comparator_en, 1'b0);
        wr(`SPRX_ADDR_MODE, 8'h00);
        sel <= 2'h0;
        wr(`SPRX_ADDR_GPA, 8'h98);
        $display("test input select done");
        for (int f = 0; f < 192; f++) begin
            sf(24'h00F00F, 1'b0, f[0], cs[f], f == 0, 1'b0);
            check("user pin", gp_pin_out[0], f[0]);
            sf(24'h0FF0F0, 1'b0, 1'b1, ~cs[f], 1'b0, 1'b1);
        end
        check("flag", status_update_flag, 1'b1);
        check("flag pin", gp_pin_out[1], 1'b1);
        wr(`SPRX_ADDR_CS1, 8'hFF);
        for (int i = 0; i < 5; i++) rd(7'(`SPRX_ADDR_CS1 + i), cs[8*i +: 8]);
        rd(`SPRX_ADDR_FLAG, 8'h01);
        rd(`SPRX_ADDR_FLAG, 8'h00);
        #1 check("flag pin", gp_pin_out[1], 1'b0);
        $display("test status block done");
        for (int m = 0; m < 2; m++) begin
            wr(`SPRX_ADDR_MODE, {1'b0, m[0], 6'h00});
            for (int w = 0; w < 3; w++) begin
                @(posedge ref_clk);
                aif_word_len <= w[1:0];
                sf(24'hFEDCBA, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
                n = (w == 0) ? 16 : (w == 1) ? 20 : 24;
                if (m == 0 && n > 20) n = 20;
                check("aif len", aif_sample_reg, keep(24'hFEDCBA, n));
                check("tx len", tx_sample_reg, keep(24'hFEDCBA, m ? 24 : 20));
                check("dac", dac1_sample_reg, keep(24'hFEDCBA, m ? 24 : 20));
                check("preemphasis_flag", dac1_preemphasis_flag_en_reg, 1'b1);
                check("mute", dac1_mute_reg, 1'b0);
            end
        end
        @(posedge ref_clk);
        route_to_dac1 <= 1'b0;
        sf(24'h123456, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        check("mute", dac1_mute_reg, 1'b1);
        check("preemphasis_flag", dac1_preemphasis_flag_en_reg, 1'b0);
        $display("test truncation and routing done");
        print_verdict;
    end
endmodule
`default_nettype wire
